// File: design/tx_clock_map.svh
// Register offsets, field positions, codes and counts of the transmit clock block
`ifndef TX_CLOCK_MAP_SVH
`define TX_CLOCK_MAP_SVH

`define OFF_CTRL        8'h00
`define OFF_STATUS      8'h04
`define OFF_LANE_A      8'h08
`define OFF_LANE_B      8'h0C

`define CTRL_TXSEL_LSB  0
`define CTRL_RXSEL_LSB  2
`define CTRL_RATE_BIT   4
`define CTRL_MODE0_LSB  6
`define CTRL_MODE1_LSB  8
`define CTRL_RESET      32'h0000_0155

`define ST_INVALID_BIT  0
`define ST_MULT_LSB     1
`define ST_MODE_LSB     6
`define ST_LOCKA_BIT    10
`define ST_LOCKB_BIT    11

`define TRI_LOW         2'h0
`define TRI_MID         2'h1
`define TRI_HIGH        2'h2

`define MULT_FULL       5'h0A
`define MULT_HALF       5'h14
`define ALIGN_MIN_EDGES 2'h2

`endif

// File: design/tx_clock_pkg.sv
// Types shared by the transmit clock block
package tx_clock_pkg;
    typedef enum logic [2:0] {
        AL_IDLE  = 3'b001,
        AL_TRACK = 3'b010,
        AL_LOCK  = 3'b100
    } align_state_t;

    typedef logic [1:0] tri_sel_t;
endpackage : tx_clock_pkg

// File: design/lane_if.sv
// Signals between the clock control top and one lane input register
`timescale 1ns/1ps
interface lane_if;
    logic        cap_tick;
    logic        char_tick;
    logic        align_req;
    logic [9:0]  din;
    logic [9:0]  dout;
    logic [3:0]  offset;
    logic        locked;

    modport top  (output cap_tick, char_tick, align_req, din, input dout, offset, locked);
    modport lane (input cap_tick, char_tick, align_req, din, output dout, offset, locked);
endinterface : lane_if

// File: design/lane_capture.sv
// One lane: input register plus phase-align hand-off to the character clock
`timescale 1ns/1ps
module lane_capture (
    // Clock and reset
    input  wire logic CLK,
    input  wire logic SYS_RST,
    // Link to the top
    lane_if.lane      lif
);
    tx_clock_pkg::align_state_t st_q, st_d;
    logic [9:0] in_q, in_d;
    logic [9:0] out_q, out_d;
    logic [3:0] phase_q, phase_d;
    logic [3:0] off_q, off_d;

    // Next state: load on capture edge, move to encoder side on char tick
    always_comb
    begin
        st_d    = st_q;
        in_d    = in_q;
        out_d   = out_q;
        off_d   = off_q;
        phase_d = (phase_q == 4'hF) ? phase_q : phase_q + 4'h1;
        if (lif.cap_tick)
        begin
            in_d    = lif.din;
            phase_d = 4'h0;
        end
        if (lif.char_tick)
            out_d = in_q;
        case (st_q)
            tx_clock_pkg::AL_IDLE:
                if (lif.align_req)
                    st_d = tx_clock_pkg::AL_TRACK;
            tx_clock_pkg::AL_TRACK:
            begin
                // Phase may slip here; characters can be dropped or repeated
                if (lif.char_tick)
                    off_d = phase_q;
                if (!lif.align_req)
                    st_d = tx_clock_pkg::AL_LOCK;
            end
            tx_clock_pkg::AL_LOCK:
                if (lif.align_req)
                    st_d = tx_clock_pkg::AL_TRACK;
            default:
                st_d = tx_clock_pkg::AL_IDLE;
        endcase
    end

    // State registers
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            st_q    <= tx_clock_pkg::AL_IDLE;
            in_q    <= 10'h000;
            out_q   <= 10'h000;
            phase_q <= 4'h0;
            off_q   <= 4'h0;
        end
        else
        begin
            st_q    <= st_d;
            in_q    <= in_d;
            out_q   <= out_d;
            phase_q <= phase_d;
            off_q   <= off_d;
        end
    end

    assign lif.dout   = out_q;
    assign lif.offset = off_q;
    assign lif.locked = (st_q == tx_clock_pkg::AL_LOCK);

    // Checks
    chk_capture_loads: assert property (@(posedge CLK) disable iff (SYS_RST)
        lif.cap_tick |=> in_q == $past(lif.din))
        else $error("input register missed capture");
    chk_lock_freezes: assert property (@(posedge CLK) disable iff (SYS_RST)
        (st_q == tx_clock_pkg::AL_LOCK && !lif.align_req) |=> $stable(off_q))
        else $error("phase moved while locked");
    chk_track_enters: assert property (@(posedge CLK) disable iff (SYS_RST)
        (lif.align_req && st_q != tx_clock_pkg::AL_TRACK) |=> st_q == tx_clock_pkg::AL_TRACK)
        else $error("alignment did not start");
endmodule : lane_capture

// File: design/tx_clock_ctrl.sv
// Transmit clock source select, rate control and synthesized clock output
//
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`include "tx_clock_map.svh"

// What this block does
// - With the source select LOW both lane input registers load on the reference clock rise.
// - With the source select MID each lane captures data and control on its own clock rise.
// - With the source select HIGH every lane input register loads on the lane A clock rise.
// - The transmit PLL multiplies the reference by 20 at HIGH rate and by 10 at LOW rate.
// - Receive output clocks taken from the reference follow its frequency and duty cycle.
// - A true and complement clock runs at reference rate when LOW and double when HIGH.
// - Each lane realigns its phase while the phase-align reset is LOW and holds it when HIGH.
// - The two ternary mode inputs decode into one of nine transmit operating modes.
// - Each three-level select is LOW, MID or HIGH, and an unconnected one reads as MID.
// - At half-rate reference, reference-timed inputs are sampled on both reference edges.
module tx_clock_ctrl (
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        SYS_RST,
    // APB slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // Clock pins from the host side
    input  wire logic        REFERENCE_CLOCK_IN,
    input  wire logic        TX_INPUT_CLOCK_A,
    input  wire logic        TX_INPUT_CLOCK_B,
    input  wire logic        TX_PHASE_ALIGN_RESET_N,
    // Parallel data pins
    input  wire logic [7:0]  TX_PARALLEL_DATA_A,
    input  wire logic [1:0]  TX_CONTROL_CODE_A,
    input  wire logic [7:0]  TX_PARALLEL_DATA_B,
    input  wire logic [1:0]  TX_CONTROL_CODE_B,
    // Lane outputs toward the encoder
    output logic      [9:0]  LANE_A_CHAR,
    output logic      [9:0]  LANE_B_CHAR,
    output logic             CHAR_TICK,
    // Generated clocks
    output logic             TX_SYNTH_CLOCK_OUT,
    output logic             TX_SYNTH_CLOCK_OUT_N,
    output logic             RX_OUTPUT_CLOCK_A,
    output logic             RX_OUTPUT_CLOCK_C
);
    logic [31:0] ctrl_q, ctrl_d;
    logic [31:0] rdata_q, rdata_d;
    logic [2:0]  ref_s, clka_s, clkb_s, rst_s;
    logic [9:0]  da_s1, da_s2, db_s1, db_s2;
    logic        ref_rise, ref_fall, ref_any, a_rise, b_rise;
    logic [1:0]  tx_sel, rx_sel, mode0, mode1;
    logic        rate_half;
    logic [4:0]  pll_mult;
    logic [3:0]  mode_idx;
    logic        invalid_cfg;
    logic        cap_a, cap_b, char_tick;
    logic [1:0]  low_cnt_q, low_cnt_d;
    logic [7:0]  since_q, since_d, half_q, half_d;
    logic        synth_q, synth_d;
    logic        access, setup, mapped;
    logic [31:0] status;

    lane_if lane_a ();
    lane_if lane_b ();

    // Resolve a three-level select; the floating code reads as MID
    function automatic logic [1:0] tri_resolve(input tx_clock_pkg::tri_sel_t v);
        tri_resolve = (v == 2'h3) ? `TRI_MID : v;
    endfunction : tri_resolve

    // Pin synchronisers; stage 0 feeds only stage 1
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            ref_s  <= 3'h0;
            clka_s <= 3'h0;
            clkb_s <= 3'h0;
            rst_s  <= 3'h7;
            da_s1  <= 10'h000;
            da_s2  <= 10'h000;
            db_s1  <= 10'h000;
            db_s2  <= 10'h000;
        end
        else
        begin
            ref_s  <= {ref_s[1:0], REFERENCE_CLOCK_IN};
            clka_s <= {clka_s[1:0], TX_INPUT_CLOCK_A};
            clkb_s <= {clkb_s[1:0], TX_INPUT_CLOCK_B};
            rst_s  <= {rst_s[1:0], TX_PHASE_ALIGN_RESET_N};
            da_s1  <= {TX_PARALLEL_DATA_A, TX_CONTROL_CODE_A};
            da_s2  <= da_s1;
            db_s1  <= {TX_PARALLEL_DATA_B, TX_CONTROL_CODE_B};
            db_s2  <= db_s1;
        end
    end

    // Edge events from synchronised stages 1 and 2
    assign ref_rise = ref_s[1] & ~ref_s[2];
    assign ref_fall = ~ref_s[1] & ref_s[2];
    assign ref_any  = ref_rise | ref_fall;
    assign a_rise   = clka_s[1] & ~clka_s[2];
    assign b_rise   = clkb_s[1] & ~clkb_s[2];

    // Configuration decode
    assign tx_sel    = tri_resolve(ctrl_q[`CTRL_TXSEL_LSB +: 2]);
    assign rx_sel    = tri_resolve(ctrl_q[`CTRL_RXSEL_LSB +: 2]);
    assign mode0     = tri_resolve(ctrl_q[`CTRL_MODE0_LSB +: 2]);
    assign mode1     = tri_resolve(ctrl_q[`CTRL_MODE1_LSB +: 2]);
    assign rate_half = ctrl_q[`CTRL_RATE_BIT];
    assign pll_mult  = rate_half ? `MULT_HALF : `MULT_FULL;
    assign mode_idx  = ({2'h0, mode1} * 4'h3) + {2'h0, mode0};
    // Flag only; the software side owns keeping clear of this pairing
    assign invalid_cfg = rate_half && (tx_sel != `TRI_LOW);

    // Character rate: one tick per full-rate reference period, two at half rate
    assign char_tick = rate_half ? ref_any : ref_rise;

    // Capture event per lane from the selected source
    always_comb
    begin
        case (tx_sel)
            `TRI_LOW:
            begin
                cap_a = char_tick;
                cap_b = char_tick;
            end
            `TRI_MID:
            begin
                cap_a = a_rise;
                cap_b = b_rise;
            end
            `TRI_HIGH:
            begin
                cap_a = a_rise;
                cap_b = a_rise;
            end
            default:
            begin
                cap_a = char_tick;
                cap_b = char_tick;
            end
        endcase
    end

    // Phase-align request needs two reference rises with reset low
    always_comb
    begin
        low_cnt_d = low_cnt_q;
        if (rst_s[1])
            low_cnt_d = 2'h0;
        else if (ref_rise && low_cnt_q != `ALIGN_MIN_EDGES)
            low_cnt_d = low_cnt_q + 2'h1;
    end

    // Synthesized clock: toggle at each reference edge, and mid-way at HIGH rate
    always_comb
    begin
        since_d = (since_q == 8'hFF) ? since_q : since_q + 8'h01;
        half_d  = half_q;
        synth_d = synth_q;
        if (ref_any)
        begin
            since_d = 8'h00;
            half_d  = since_q;
            synth_d = ~synth_q;
        end
        else if (rate_half && since_q == {1'b0, half_q[7:1]} && half_q > 8'h01)
            synth_d = ~synth_q;
    end

    // Clock generation state
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            low_cnt_q <= 2'h0;
            since_q   <= 8'h00;
            half_q    <= 8'h00;
            synth_q   <= 1'b0;
        end
        else
        begin
            low_cnt_q <= low_cnt_d;
            since_q   <= since_d;
            half_q    <= half_d;
            synth_q   <= synth_d;
        end
    end

    // Lane links
    assign lane_a.cap_tick  = cap_a;
    assign lane_a.char_tick = char_tick;
    assign lane_a.align_req = (low_cnt_q == `ALIGN_MIN_EDGES);
    assign lane_a.din       = da_s2;
    assign lane_b.cap_tick  = cap_b;
    assign lane_b.char_tick = char_tick;
    assign lane_b.align_req = (low_cnt_q == `ALIGN_MIN_EDGES);
    assign lane_b.din       = db_s2;

    lane_capture u_lane_a (
        .CLK     (CLK),
        .SYS_RST (SYS_RST),
        .lif     (lane_a)
    );

    lane_capture u_lane_b (
        .CLK     (CLK),
        .SYS_RST (SYS_RST),
        .lif     (lane_b)
    );

    // APB decode; zero wait states
    assign setup  = PSEL & ~PENABLE;
    assign access = PSEL & PENABLE;
    assign mapped = (PADDR == `OFF_CTRL) || (PADDR == `OFF_STATUS) ||
                    (PADDR == `OFF_LANE_A) || (PADDR == `OFF_LANE_B);
    assign status = {20'h0_0000, lane_b.locked, lane_a.locked, mode_idx,
                     pll_mult, invalid_cfg};

    // Register next values; read data is latched in setup so it comes from a flop
    always_comb
    begin
        ctrl_d  = ctrl_q;
        rdata_d = rdata_q;
        if (access && PWRITE && PADDR == `OFF_CTRL)
            ctrl_d = {22'h00_0000, PWDATA[9:0]};
        if (setup)
        begin
            case (PADDR)
                `OFF_CTRL:   rdata_d = ctrl_q;
                `OFF_STATUS: rdata_d = status;
                `OFF_LANE_A: rdata_d = {18'h0_0000, lane_a.offset, lane_a.dout};
                `OFF_LANE_B: rdata_d = {18'h0_0000, lane_b.offset, lane_b.dout};
                default:     rdata_d = 32'h0000_0000;
            endcase
        end
    end

    // Register file
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            ctrl_q  <= `CTRL_RESET;
            rdata_q <= 32'h0000_0000;
        end
        else
        begin
            ctrl_q  <= ctrl_d;
            rdata_q <= rdata_d;
        end
    end

    // Outputs
    assign PRDATA               = rdata_q;
    assign PREADY               = 1'b1;
    assign PSLVERR              = access & ~mapped;
    assign LANE_A_CHAR          = lane_a.dout;
    assign LANE_B_CHAR          = lane_b.dout;
    assign CHAR_TICK            = char_tick;
    assign TX_SYNTH_CLOCK_OUT   = synth_q;
    assign TX_SYNTH_CLOCK_OUT_N = ~synth_q;
    // Reference-driven receive clocks mirror it at either rate; idle otherwise
    assign RX_OUTPUT_CLOCK_A    = (rx_sel == `TRI_LOW) & ref_s[2];
    assign RX_OUTPUT_CLOCK_C    = (rx_sel == `TRI_LOW) & ref_s[2];

    // Checks
    chk_pll_mult_rate: assert property (@(posedge CLK) disable iff (SYS_RST)
        pll_mult == (ctrl_q[`CTRL_RATE_BIT] ? 5'h14 : 5'h0A))
        else $error("wrong PLL multiplier");
    chk_invalid_flag: assert property (@(posedge CLK) disable iff (SYS_RST)
        (ctrl_q[`CTRL_RATE_BIT] && ctrl_q[1:0] == 2'h2) |-> status[0])
        else $error("invalid pairing not flagged");
    chk_mode_nine: assert property (@(posedge CLK) disable iff (SYS_RST)
        mode_idx < 4'h9)
        else $error("mode index out of range");
    chk_float_mid: assert property (@(posedge CLK) disable iff (SYS_RST)
        (ctrl_q[1:0] == 2'h3) |-> (cap_a == a_rise && cap_b == b_rise))
        else $error("floating select not taken as MID");
    chk_shared_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        (tx_sel == `TRI_HIGH && a_rise) |-> cap_b)
        else $error("lane B not clocked from lane A clock");
    chk_half_both: assert property (@(posedge CLK) disable iff (SYS_RST)
        (tx_sel == `TRI_LOW && rate_half && ref_fall) |-> (cap_a && cap_b))
        else $error("falling edge not sampled at half rate");
    chk_rx_follow: assert property (@(posedge CLK) disable iff (SYS_RST)
        (rx_sel == `TRI_LOW) |-> (RX_OUTPUT_CLOCK_A == ref_s[2]))
        else $error("receive clock not following reference");
    chk_synth_toggle: assert property (@(posedge CLK) disable iff (SYS_RST)
        ref_any |=> TX_SYNTH_CLOCK_OUT != $past(TX_SYNTH_CLOCK_OUT))
        else $error("synth clock did not toggle on reference edge");
    chk_align_two: assert property (@(posedge CLK) disable iff (SYS_RST)
        $rose(lane_a.align_req) |-> $past(!rst_s[1], 1) && $past(!rst_s[1], 2))
        else $error("alignment started too early");
endmodule : tx_clock_ctrl

// File: test/host_model.sv
// Host-side model: reference clock, lane clocks, phase-align reset and lane data
`timescale 1ns/1ps
module host_model #(
    parameter int HALF = 8
) (
    // Clock and reset
    input  wire logic       CLK,
    input  wire logic       SYS_RST,
    // Requests from the bench
    input  wire logic       en_a,
    input  wire logic       en_b,
    input  wire logic       align_req,
    input  wire logic [9:0] char_a,
    input  wire logic [9:0] char_b,
    // Pins toward the block
    output logic            ref_clk,
    output logic            clk_a,
    output logic            clk_b,
    output logic            align_n,
    output logic [9:0]      pins_a,
    output logic [9:0]      pins_b
);
    int         cnt;
    int         rises;
    logic [1:0] dly;

    // Lane clocks are delayed copies of the reference, so they stay coherent; stopped ones sit low
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            cnt <= 0;
            ref_clk <= 1'b0;
            dly <= 2'h0;
            clk_a <= 1'b0;
            clk_b <= 1'b0;
            pins_a <= 10'h000;
            pins_b <= 10'h000;
        end
        else
        begin
            cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
            if (cnt == HALF - 1)
                ref_clk <= ~ref_clk;
            dly <= {dly[0], ref_clk};
            clk_a <= en_a & dly[1];
            clk_b <= en_b & dly[1];
            pins_a <= char_a;
            pins_b <= char_b;
        end
    end

    // Phase-align reset is released only after three reference rises, never fewer than two
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            align_n <= 1'b1;
            rises <= 0;
        end
        else if (!align_n)
        begin
            if (cnt == HALF - 1 && !ref_clk)
                rises <= rises + 1;
            if (!align_req && rises >= 3)
                align_n <= 1'b1;
        end
        else if (align_req)
        begin
            align_n <= 1'b0;
            rises <= 0;
        end
    end
endmodule : host_model

// File: test/test_tx_clock_ctrl.sv
// Self-checking bench for the transmit clock control block
`timescale 1ns/1ps
`include "tx_clock_map.svh"
module test_tx_clock_ctrl;
    logic        clk, sys_rst, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        ref_clk, clk_a, clk_b, align_n, en_a, en_b, align_req;
    logic [9:0]  char_a, char_b, pins_a, pins_b, lane_a, lane_b;
    logic        tick, synth, synth_n, rx_a, rx_c;
    int          n_fail, num_checks, cyc, ts, tr, tk;

    host_model #(.HALF(8)) i_host (.CLK(clk), .SYS_RST(sys_rst), .en_a(en_a), .en_b(en_b),
        .align_req(align_req), .char_a(char_a), .char_b(char_b), .ref_clk(ref_clk),
        .clk_a(clk_a), .clk_b(clk_b), .align_n(align_n), .pins_a(pins_a), .pins_b(pins_b));

    tx_clock_ctrl i_dut (.CLK(clk), .SYS_RST(sys_rst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .REFERENCE_CLOCK_IN(ref_clk), .TX_INPUT_CLOCK_A(clk_a),
        .TX_INPUT_CLOCK_B(clk_b), .TX_PHASE_ALIGN_RESET_N(align_n),
        .TX_PARALLEL_DATA_A(pins_a[9:2]), .TX_CONTROL_CODE_A(pins_a[1:0]),
        .TX_PARALLEL_DATA_B(pins_b[9:2]), .TX_CONTROL_CODE_B(pins_b[1:0]),
        .LANE_A_CHAR(lane_a), .LANE_B_CHAR(lane_b), .CHAR_TICK(tick),
        .TX_SYNTH_CLOCK_OUT(synth), .TX_SYNTH_CLOCK_OUT_N(synth_n),
        .RX_OUTPUT_CLOCK_A(rx_a), .RX_OUTPUT_CLOCK_C(rx_c));

    // Free-running 100 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish

    // Hang guard: the whole sequence needs well under this many cycles
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            n_fail++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    // One APB transfer; request held until pready is sampled high, only the hang guard ends a wait
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rdat, output logic serr);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rdat = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m,
                         input string what);
        apb(1'b0, a, 32'h0, rd, err);
        chk(rd & m, exp, what);
    endtask : rdchk

    function automatic logic [31:0] mk(int tx, int rx, int r, int m0, int m1);
        return 32'(tx) << `CTRL_TXSEL_LSB | 32'(rx) << `CTRL_RXSEL_LSB | 32'(r) << `CTRL_RATE_BIT
             | 32'(m0) << `CTRL_MODE0_LSB | 32'(m1) << `CTRL_MODE1_LSB;
    endfunction : mk

    // Floating ternary code reads as MID; invalid only for non-LOW source with half rate
    function automatic logic [31:0] exp_st(int tx, int r, int m0, int m1);
        int e0;
        int e1;
        e0 = (m0 == 3) ? 1 : m0;
        e1 = (m1 == 3) ? 1 : m1;
        return 32'(e1 * 3 + e0) << `ST_MODE_LSB | 32'(tx != 0 && r != 0) << `ST_INVALID_BIT
             | (r != 0 ? 32'(`MULT_HALF) : 32'(`MULT_FULL)) << `ST_MULT_LSB;
    endfunction : exp_st

    // Counts synth and rx clock changes and character ticks over 64 cycles, four reference periods
    task automatic measure();
        logic ps;
        logic pr;
        ts = 0;
        tr = 0;
        tk = 0;
        @(posedge clk);
        ps = synth;
        pr = rx_a;
        repeat (64)
        begin
            @(posedge clk);
            ts += int'(synth !== ps);
            tr += int'(rx_a !== pr);
            tk += int'(tick === 1'b1);
            ps = synth;
            pr = rx_a;
            chk({30'h0, synth_n, rx_c}, {30'h0, ~synth, rx_a}, "clock pairs");
        end
    endtask : measure

    // Main sequence
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {en_a, en_b, align_req, char_a, char_b} = '0;
        {n_fail, num_checks, cyc} = '0;
        sys_rst = 1'b1;
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        rdchk(`OFF_CTRL, `CTRL_RESET, 32'h3FF, "ctrl reset");
        rdchk(`OFF_STATUS, exp_st(1, 1, 1, 1), 32'h3FF, "status reset");
        apb(1'b0, 8'h10, 32'h0, rd, err);
        chk({31'h0, err}, 32'h1, "unmapped error");
        // Every source, rate and mode code, floating code included
        for (int tx = 0; tx < 4; tx++)
            for (int r = 0; r < 2; r++)
                for (int m = 0; m < 16; m++)
                begin
                    apb(1'b1, `OFF_CTRL, mk(tx, 0, r, m % 4, m / 4), rd, err);
                    rdchk(`OFF_STATUS, exp_st(tx, r, m % 4, m / 4), 32'h3FF, "status");
                end
        // Synth clock rate and receive clocks from the reference
        for (int k = 0; k < 4; k++)
        begin
            apb(1'b1, `OFF_CTRL, mk(0, (k / 2) * 1, k % 2, 0, 0), rd, err);
            repeat (40) @(posedge clk);
            measure();
            chk(32'(ts), (k % 2) ? 32'd16 : 32'd8, "synth toggles");
            chk(32'(tr), (k < 2) ? 32'd8 : 32'd0, "rx toggles");
            chk(32'(tk), (k % 2) ? 32'd8 : 32'd4, "char ticks");
        end
        // Input register clock source: lane B clock stopped in the second phase
        for (int s = 0; s < 3; s++)
        begin
            apb(1'b1, `OFF_CTRL, mk(0, 1, 0, 0, 0), rd, err);
            en_a <= 1'b1;
            en_b <= 1'b1;
            char_a <= 10'h155;
            char_b <= 10'h2AA;
            repeat (100) @(posedge clk);
            apb(1'b1, `OFF_CTRL, mk(s, 1, 0, 0, 0), rd, err);
            en_a <= (s != 0);
            en_b <= 1'b0;
            char_a <= 10'h0F3;
            char_b <= 10'h30C;
            repeat (100) @(posedge clk);
            chk({22'h0, lane_a}, 32'h0F3, "lane a char");
            chk({22'h0, lane_b}, (s == 1) ? 32'h2AA : 32'h30C, "lane b char");
            rdchk(`OFF_LANE_A, 32'h0F3, 32'h3FF, "lane a reg");
        end
        // Phase realigns while reset is low, then holds
        apb(1'b1, `OFF_CTRL, mk(1, 1, 0, 0, 0), rd, err);
        en_b <= 1'b1;
        align_req <= 1'b1;
        repeat (80) @(posedge clk);
        rdchk(`OFF_STATUS, 32'h0, 32'hC00, "tracking");
        align_req <= 1'b0;
        repeat (120) @(posedge clk);
        rdchk(`OFF_STATUS, 32'hC00, 32'hC00, "locked");
        tally_and_finish();
    end
endmodule : test_tx_clock_ctrl
